// [design/wort_pkg.sv]
// Package with register map, field layout, reset values and timing counts of the wake timer
`default_nettype none

package wort_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the register port
  // ----------------------------------------------------------------
  localparam logic [5:0] WORT_ADDR_TMO_HIGH = 6'h1e;
  localparam logic [5:0] WORT_ADDR_TMO_LOW  = 6'h1f;
  localparam logic [5:0] WORT_ADDR_CONTROL  = 6'h20;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int WORT_BIT_PD      = 7;
  localparam int WORT_SEL_MSB     = 6;
  localparam int WORT_SEL_LSB     = 4;
  localparam int WORT_BIT_CAL     = 3;
  localparam int WORT_RES_MSB     = 1;
  localparam int WORT_RES_LSB     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WORT_RST_TMO_HIGH = 8'h87;
  localparam logic [7:0] WORT_RST_TMO_LOW  = 8'h6b;
  localparam logic       WORT_RST_PD       = 1'h1;
  localparam logic [2:0] WORT_RST_SEL      = 3'h7;
  localparam logic       WORT_RST_CAL      = 1'h1;
  localparam logic [1:0] WORT_RST_RES      = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int WORT_CLK_PERIOD_NS = 100;  // Crystal-side clock period
  localparam int WORT_RC_DIV        = 750;  // Crystal cycles per RC period
  localparam int WORT_CAL_PERIODS   = 4;    // RC periods an initial calibration lasts
  localparam int WORT_RES_SHIFT     = 5;    // Prescaler grows by 2^5 per resolution step

  // Second-event delays in RC periods, indexed by the select field
  localparam logic [6:0] WORT_DLY_PLAIN [8] = '{7'h04, 7'h06, 7'h08, 7'h0c,
                                                7'h10, 7'h18, 7'h20, 7'h30};
  localparam logic [6:0] WORT_DLY_SYNC  [8] = '{7'h06, 7'h18, 7'h20, 7'h12,
                                                7'h40, 7'h60, 7'h1c, 7'h5c};

endpackage

`default_nettype wire

// [design/wort_timer.sv]
// Wake timer: timeout registers, control register, RC tick, prescaler and two wake events
//
// Behaviour
// (R1) Timeout held in two readable byte registers
// (R2) Timeout equals steps times scaled RC period
// (R3) Timeout resets to 0x876b, about 2.6 seconds
// (R4) Power-down resets set; clearing starts calibration
// (R5) RC period is 750 crystal cycles
// (R6) Select field picks second-event delay, resets 7
// (R7) Calibration enable resets set; clear disables
// (R8) Resolution resets 0; scales step by 2^(5n)
// (R9) Count steps, fire first event, restart
`timescale 1ns/100ps
`default_nettype none

module wort_timer
  import wort_pkg::*;
#(
  parameter int RC_DIV      = WORT_RC_DIV,
  parameter int CAL_PERIODS = WORT_CAL_PERIODS
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // Mode input from the polling logic
  input  wire logic       wake_autosync,
  // Wake events and status
  output var  logic       first_wake_event,
  output var  logic       second_wake_event,
  output var  logic       rc_osc_cal_enable_active
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RC_DIV < 9 || RC_DIV > 65535)
  begin : g_chk_div
    $error("RC_DIV out of range");
  end
  if (CAL_PERIODS < 1 || CAL_PERIODS > 255)
  begin : g_chk_cal
    $error("CAL_PERIODS out of range");
  end

  localparam logic [15:0] DIV_LAST = 16'(RC_DIV - 1);
  localparam logic [7:0]  CAL_LAST = 8'(CAL_PERIODS);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  tmo_high_r;      // Upper timeout byte
  logic [7:0]  tmo_low_r;       // Lower timeout byte
  logic        pd_r;            // RC oscillator power-down
  logic [2:0]  sel_r;           // Second-event delay select
  logic        cal_en_r;        // Calibration enable
  logic [1:0]  res_r;           // Resolution
  logic [15:0] div_r;           // Crystal-to-RC divider
  logic        tick_r;          // One-cycle RC period mark
  logic [14:0] pre_r;           // Resolution prescaler
  logic [15:0] step_r;          // Timeout step counter
  logic [6:0]  dly_r;           // Second-event countdown
  logic        dly_busy_r;      // Countdown running
  logic [7:0]  cal_cnt_r;       // Calibration countdown
  logic        first_r;
  logic        second_r;
  logic        cal_r;
  logic [7:0]  rdata_r;

  // ----------------------------------------------------------------
  // Decode and next-value logic
  // ----------------------------------------------------------------
  wire         wr_high  = reg_wr && (reg_addr == WORT_ADDR_TMO_HIGH);
  wire         wr_low   = reg_wr && (reg_addr == WORT_ADDR_TMO_LOW);
  wire         wr_ctrl  = reg_wr && (reg_addr == WORT_ADDR_CONTROL);
  wire [15:0]  timeout  = {tmo_high_r, tmo_low_r};                   // [R1]
  wire [7:0]   ctrl_rd  = {pd_r, sel_r, cal_en_r, 1'b0, res_r};
  // Reserved bit reads zero, unmapped offsets read zero
  wire [7:0]   rdata_nxt = (reg_addr == WORT_ADDR_TMO_HIGH) ? tmo_high_r :
                           (reg_addr == WORT_ADDR_TMO_LOW)  ? tmo_low_r  :
                           (reg_addr == WORT_ADDR_CONTROL)  ? ctrl_rd    : 8'h00;
  // Clearing power-down while it was set, with the calibration enable bit written 1, starts a calibration
  wire         pd_clear = wr_ctrl && pd_r && !reg_wdata[WORT_BIT_PD];
  wire         cal_go   = pd_clear && reg_wdata[WORT_BIT_CAL];       // [R4] [R7]
  wire [14:0]  pre_last = 15'((32'h1 << (WORT_RES_SHIFT * res_r)) - 32'h1); // [R8]
  wire         step_end = tick_r && (pre_r == pre_last);
  // A zero timeout wraps and runs the full 2^16 steps
  wire         tmo_hit  = step_end && (step_r == 16'(timeout - 16'h1)); // [R2] [R9]
  wire [6:0]   dly_sel  = wake_autosync ? WORT_DLY_SYNC[sel_r] : WORT_DLY_PLAIN[sel_r]; // [R6]
  wire         dly_done = dly_busy_r && tick_r && (dly_r == 7'h01);
  wire         div_wrap = (div_r == DIV_LAST);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tmo_high_r <= WORT_RST_TMO_HIGH;                               // [R3]
      tmo_low_r  <= WORT_RST_TMO_LOW;                                // [R3]
      pd_r       <= WORT_RST_PD;                                     // [R4]
      sel_r      <= WORT_RST_SEL;                                    // [R6]
      cal_en_r   <= WORT_RST_CAL;                                    // [R7]
      res_r      <= WORT_RST_RES;                                    // [R8]
    end
    else if (wr_ctrl)
    begin
      pd_r     <= reg_wdata[WORT_BIT_PD];
      sel_r    <= reg_wdata[WORT_SEL_MSB:WORT_SEL_LSB];
      cal_en_r <= reg_wdata[WORT_BIT_CAL];
      res_r    <= reg_wdata[WORT_RES_MSB:WORT_RES_LSB];
    end
    else
    begin
      // Byte writes land one at a time; software updates both bytes
      if (wr_high)
        tmo_high_r <= reg_wdata;                                     // [R1]
      if (wr_low)
        tmo_low_r <= reg_wdata;                                      // [R1]
    end
  end

  // Read data is registered, held between reads
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 8'h00;
    else if (reg_rd)
      rdata_r <= rdata_nxt;                                          // [R1]
  end

  // ----------------------------------------------------------------
  // RC period generator, stopped while powered down
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (pd_r)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_wrap ? 16'h0000 : 16'(div_r + 16'h1);            // [R5]
      tick_r <= div_wrap;                                            // [R5]
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and first-event counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_r   <= 15'h0000;
      step_r  <= 16'h0000;
      first_r <= 1'b0;
    end
    else if (pd_r)
    begin
      pre_r   <= 15'h0000;
      step_r  <= 16'h0000;
      first_r <= 1'b0;
    end
    else
    begin
      first_r <= tmo_hit;                                            // [R9]
      if (tick_r)
        pre_r <= (pre_r >= pre_last) ? 15'h0000 : 15'(pre_r + 15'h1); // [R8]
      if (tmo_hit)
        step_r <= 16'h0000;                                          // [R9]
      else if (step_end)
        step_r <= 16'(step_r + 16'h1);                               // [R2]
    end
  end

  // ----------------------------------------------------------------
  // Second event, counted in RC periods after the first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dly_r      <= 7'h00;
      dly_busy_r <= 1'b0;
      second_r   <= 1'b0;
    end
    else if (pd_r)
    begin
      dly_r      <= 7'h00;
      dly_busy_r <= 1'b0;
      second_r   <= 1'b0;
    end
    else
    begin
      second_r <= dly_done;                                          // [R6]
      if (first_r)
      begin
        dly_r      <= dly_sel;                                       // [R6]
        dly_busy_r <= 1'b1;
      end
      else if (dly_done)
        dly_busy_r <= 1'b0;
      else if (dly_busy_r && tick_r)
        dly_r <= 7'(dly_r - 7'h1);
    end
  end

  // ----------------------------------------------------------------
  // Initial calibration after power-up
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_cnt_r <= 8'h00;
      cal_r     <= 1'b0;
    end
    else if (cal_go)
    begin
      cal_cnt_r <= CAL_LAST;                                         // [R4]
      cal_r     <= 1'b1;
    end
    else if (pd_r || !cal_en_r)
    begin
      // Disabling calibration, or powering down, aborts a run
      cal_cnt_r <= 8'h00;
      cal_r     <= 1'b0;                                             // [R7]
    end
    else if (cal_r && tick_r)
    begin
      cal_cnt_r <= 8'(cal_cnt_r - 8'h1);
      cal_r     <= (cal_cnt_r != 8'h01);
    end
  end

  assign reg_rdata         = rdata_r;
  assign first_wake_event  = first_r;
  assign second_wake_event = second_r;
  assign rc_osc_cal_enable_active     = cal_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_first;
    first_r;
  endsequence
  sequence s_second_wait;
    !second_r [*8];
  endsequence

  tmo_write_a: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    wr_low |=> tmo_low_r == $past(reg_wdata))
    else $error("low timeout byte not written");
  tmo_reset_a: assert property (@(posedge clk) $rose(reset_n) |-> // [R3]
    timeout == 16'h876b && pd_r && sel_r == 3'h7 && cal_en_r)
    else $error("timeout or control reset value wrong");
  cal_start_a: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    cal_go |=> cal_r && cal_cnt_r == CAL_LAST)
    else $error("calibration did not start on power-up");
  tick_space_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    tick_r |=> !tick_r [*8])
    else $error("RC ticks too close");
  tick_gap_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    tick_r && !pd_r |-> $past(div_r) == DIV_LAST)
    else $error("RC tick at wrong divider count");
  second_gap_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    s_first |=> s_second_wait)
    else $error("second event too soon after first");
  cal_off_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    !cal_en_r && !cal_go |=> !cal_r)
    else $error("calibration runs while disabled");
  res_reset_a: assert property (@(posedge clk) $rose(reset_n) |-> res_r == 2'h0) // [R8]
    else $error("resolution reset value wrong");
  first_cause_a: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    first_r |-> $past(step_r) == 16'($past(timeout) - 16'h1) && step_r == 16'h0000)
    else $error("first event without timeout match");
  pd_quiet_a: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    pd_r |=> !first_r && !second_r)
    else $error("event while powered down");

endmodule

`default_nettype wire

// [verification/wort_testbench.sv]
// Self-checking testbench of the wake timer: registers, event timing, calibration
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import wort_pkg::*;
  // ----------------------------------------------------------------
  // Settings and signals
  // ----------------------------------------------------------------
  localparam int DIV  = 9;    // Short RC period keeps the run brief
  localparam int CALP = 4;    // Calibration length in RC periods
  logic       clk;            // Crystal-side clock
  logic       reset_n;        // Async reset, active low
  logic [5:0] reg_addr;       // Register offset
  logic       reg_wr;         // Write strobe
  logic       reg_rd;         // Read strobe
  logic [7:0] reg_wdata;      // Write data
  logic [7:0] reg_rdata;      // Read data
  logic       wake_autosync;  // Delay table select
  logic       first_wake_event;
  logic       second_wake_event;
  logic       rc_osc_cal_enable_active;
  int         err_count;      // Mismatches
  int         total_checks;   // Comparisons made

  wort_timer #(.RC_DIV(DIV), .CAL_PERIODS(CALP)) dut (
    .clk               (clk),
    .reset_n           (reset_n),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .wake_autosync     (wake_autosync),
    .first_wake_event  (first_wake_event),
    .second_wake_event (second_wake_event),
    .rc_osc_cal_enable_active     (rc_osc_cal_enable_active)
  );

  // 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  // Second-event delay in RC periods, both tables
  function automatic int dly(input bit a, input int s);
    int plain [8];
    int sync [8];
    plain = '{4, 6, 8, 12, 16, 24, 32, 48};
    sync  = '{6, 24, 32, 18, 64, 96, 28, 92};
    return a ? sync[s] : plain[s];
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      err_count++;
    end
  endtask

  // One write; returns once the taking edge has landed
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One read and comparison of the returned byte
  task automatic chk_rd(input string what, input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, 32'(exp), 32'(reg_rdata));
  endtask

  // Counts cycles up to the next first event, noting a second event on the way
  task automatic count_to_first(input int lim, output int n, output int d);
    n = 0;
    d = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (second_wake_event === 1'b1 && d == 0)
        d = n;
    end while (first_wake_event !== 1'b1 && n < lim);
  endtask

  // Configure with the oscillator off, start it, then time two event periods
  task automatic run_ev(input int t, input int res, input int s, input bit a, input bit cal);
    int         per;
    int         n;
    int         d;
    logic [7:0] c;
    per = t * (1 << (5 * res)) * DIV;
    c = {1'b1, 3'(s), cal, 1'b0, 2'(res)};
    wr(WORT_ADDR_CONTROL, c);
    wr(WORT_ADDR_TMO_HIGH, 8'(t >> 8));
    wr(WORT_ADDR_TMO_LOW, 8'(t));
    @(posedge clk);
    wake_autosync <= a;
    c[7] = 1'b0;
    wr(WORT_ADDR_CONTROL, c);
    chk("cal active at start", 32'(cal), 32'(rc_osc_cal_enable_active));
    count_to_first(per + 4 * DIV, n, d);
    chk("first event seen", 32'h1, 32'(first_wake_event));
    count_to_first(per + 4 * DIV, n, d);
    chk("cal over", 32'h0, 32'(rc_osc_cal_enable_active));
    chk("second delay", 32'(dly(a, s) * DIV), 32'(d));
    chk("first period", 32'(per), 32'(n));
  endtask

  // Single exit of the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog: about one and a half times the expected run length
  initial
  begin
    #(100000 * 100);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] c;
    int         n;
    int         d;
    err_count = 0;
    total_checks = 0;
    reset_n = 1'b0;
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    wake_autosync = 1'b0;
    void'($urandom(23));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values of all three registers
    chk_rd("timeout high", WORT_ADDR_TMO_HIGH, 8'h87);
    chk_rd("timeout low", WORT_ADDR_TMO_LOW, 8'h6b);
    chk_rd("control", WORT_ADDR_CONTROL, 8'hf8);
    $display("test reset_values done");
    // Random read-back; oscillator kept off, reserved bit reads 0
    for (int i = 0; i < 6; i++)
    begin
      h = 8'($urandom);
      l = 8'($urandom);
      c = 8'($urandom) | 8'h80;
      wr(WORT_ADDR_TMO_HIGH, h);
      wr(WORT_ADDR_TMO_LOW, l);
      wr(WORT_ADDR_CONTROL, c);
      chk_rd("timeout high", WORT_ADDR_TMO_HIGH, h);
      chk_rd("timeout low", WORT_ADDR_TMO_LOW, l);
      chk_rd("control", WORT_ADDR_CONTROL, c & 8'hfb);
    end
    // Unmapped offset neither stores nor disturbs the map
    wr(6'h21, 8'h5a);
    chk_rd("unmapped", 6'h21, 8'h00);
    chk_rd("timeout high kept", WORT_ADDR_TMO_HIGH, h);
    $display("test register_access done");
    // Every select value in both tables; calibration off for select 3
    for (int s = 0; s < 8; s++)
      for (int a = 0; a < 2; a++)
        run_ev(100 + $urandom_range(20), 0, s, a[0], s != 3);
    $display("test second_event_table done");
    // Coarser resolutions scale the step
    run_ev(4, 1, $urandom_range(7), 1'($urandom), 1'b1);
    run_ev(1, 2, 0, 1'b0, 1'b1);
    $display("test resolution done");
    // Power-down silences both events
    wr(WORT_ADDR_CONTROL, 8'hf8);
    count_to_first(3000, n, d);
    chk("cycles without first event", 32'd3000, 32'(n));
    chk("second event while off", 32'h0, 32'(d));
    $display("test powerdown done");
    // Coarsest resolution: one step outlasts the 2^10 step by far
    wr(WORT_ADDR_CONTROL, 8'h83);
    wr(WORT_ADDR_TMO_HIGH, 8'h00);
    wr(WORT_ADDR_TMO_LOW, 8'h01);
    wr(WORT_ADDR_CONTROL, 8'h03);
    count_to_first(1100 * DIV, n, d);
    chk("cycles at coarsest resolution", 32'(1100 * DIV), 32'(n));
    $display("test coarsest_resolution done");
    // Reset in mid-run brings the defaults back
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk_rd("control after reset", WORT_ADDR_CONTROL, 8'hf8);
    chk_rd("timeout low after reset", WORT_ADDR_TMO_LOW, 8'h6b);
    $display("test mid_reset done");
    report_and_stop();
  end

endmodule
`default_nettype wire
